// >>> mcc_monitor_config_control.sv
// Control and configuration register bank of the system hardware monitor
`timescale 1ns/1ps

// Overview of operation
// - Power-up initialises control and trip registers
// - After power-up monitoring stopped, alert cleared
// - Primary bit 7 re-initialises, self-clears
// - Re-init keeps test and analog registers
// - Primary bit 0 runs loop, else low-power
// - Register access works in low-power state
// - Primary bit 1 enables alert output
// - Primary bit 2 enables overtemp output
// - Primary bit 3 clears alert, suspends monitoring
// - Primary bit 4 gives 45 ms reset pulse
// - Primary bit 6 clears overtemp output
// - Secondary bit 0 masks temperature alerts
// - Secondary bits 1,2 lock trip registers
// - Secondary bit 3 selects overtemp mode
// - Analog and fan measurements start together
// - Fan timing follows rate and divisor
// - Value registers readable any time
// - Test bit 0 enters full shutdown
// - Clearing shutdown restores previous state
// - Host writes write-only register pointer
// - Reset pulse needs mask2 bit 7, self-clears
module mcc_monitor_config_control
    import mcc_pkg::*;
#(
    parameter int RST_PULSE_CYC = MCC_RST_PULSE_CYC
) (
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_resetn,
    // Register access from the serial bus engine
    input  wire mcc_bus_req_t i_bus,
    input  wire logic [7:0]   i_ext_rdata,
    output logic [7:0]        o_ext_addr,
    output logic [7:0]        o_rdata,
    output logic              o_rvalid,
    // Event sources from status and comparison logic
    input  wire logic         i_int_event,
    input  wire logic         i_temp_event,
    input  wire logic         i_overtemp_req,
    // Overtemperature pin, open drain
    input  wire logic         i_overtemp_pin,
    output logic              o_overtemp_out,
    output logic              o_overtemp_oe,
    output logic              o_overtemp_ext,
    // Reset pin, open drain
    output logic              o_reset_out,
    output logic              o_reset_oe,
    // Alert pin and core control
    output logic              o_alert_n,
    output logic              o_monitor_run,
    output logic              o_low_power,
    output logic              o_shutdown,
    output logic              o_meas_start,
    output logic              o_overtemp_mode,
    output logic [7:0]        o_chmode
);

    // ========================================================
    // Reset release
    // Assertion acts at once, release reaches every state flop together on the second clock edge
    logic rst_sync1_reg;
    logic rst_sync2_reg;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    // ========================================================
    // State
    // Pulse counter constants, cut to the counter width on purpose
    localparam logic [MCC_CNT_W-1:0] PULSE_LEN = RST_PULSE_CYC[MCC_CNT_W-1:0];
    localparam logic [MCC_CNT_W-1:0] CNT_ONE   = {{(MCC_CNT_W-1){1'b0}}, 1'b1};
    localparam logic [MCC_CNT_W-1:0] CNT_ZERO  = '0;

    // Registered state, its next value and decode helpers
    mcc_state_t state_reg;
    mcc_state_t state_next;
    logic       run_now;
    logic       wr_primary;
    logic [7:0] wd;

    // Power-on values
    localparam mcc_state_t MCC_POR = '{
        primary:   MCC_RST_PRIMARY,
        secondary: MCC_RST_SECONDARY,
        mask2:     MCC_RST_MASK2,
        test:      MCC_RST_TEST,
        chmode:    MCC_RST_CHMODE,
        analog:    MCC_RST_ANALOG,
        trip_int:  MCC_RST_TRIP_INT,
        trip_ext:  MCC_RST_TRIP_EXT,
        pointer:   8'h00,
        lock:      1'b0,
        rst_cnt:   '0,
        run_d:     1'b0,
        meas_start: 1'b0,
        rdata:     8'h00,
        rvalid:    1'b0,
        ot_sync1:  1'b1,
        ot_sync2:  1'b1,
        alert_n:   1'b1,
        ot_drive:  1'b0
    };

    // Next-state logic: registers hold by default, strobes fall
    // A data access in the same cycle as a pointer write uses the old
    // pointer, so the host may send pointer and data back to back
    always_comb begin
        state_next = state_reg;
        wd         = i_bus.wdata;
        wr_primary = i_bus.data_wr && (state_reg.pointer == MCC_OFS_PRIMARY);
        state_next.rvalid     = 1'b0;
        state_next.meas_start = 1'b0;

        if (i_bus.ptr_wr) begin
            state_next.pointer = wd;
        end

        if (i_bus.data_wr) begin
            case (state_reg.pointer)
                MCC_OFS_PRIMARY: begin
                    // Bits 3 and 6 held until rewritten
                    state_next.primary = wd;
                    // Request needs enable; dropping it here
                    // keeps a later enable from firing a stale request
                    if (!state_reg.mask2[MCC_M_RST_EN]) begin
                        state_next.primary[MCC_P_RST_REQ] = 1'b0;
                    end
                    if (wd[MCC_P_REINIT]) begin
                        state_next.primary   = MCC_RST_PRIMARY;
                        state_next.secondary = MCC_RST_SECONDARY;
                        state_next.mask2     = MCC_RST_MASK2;
                        state_next.chmode    = MCC_RST_CHMODE;
                        // Lock flag is kept, only power-on reset clears it,
                        // so locked trip points keep their values
                        if (!state_reg.lock) begin
                            state_next.trip_int = MCC_RST_TRIP_INT;
                            state_next.trip_ext = MCC_RST_TRIP_EXT;
                        end
                    end
                end
                MCC_OFS_SECONDARY: begin
                    state_next.secondary = wd;
                    if (wd[MCC_S_LOCK_A] && wd[MCC_S_LOCK_B]) begin
                        state_next.lock = 1'b1;
                    end
                end
                MCC_OFS_MASK2: begin
                    state_next.mask2 = wd;
                end
                MCC_OFS_TEST: begin
                    state_next.test = wd;
                end
                MCC_OFS_CHMODE: begin
                    state_next.chmode = wd;
                end
                MCC_OFS_ANALOG: begin
                    state_next.analog = wd;
                end
                MCC_OFS_TRIP_INT: begin
                    if (!state_reg.lock) begin
                        state_next.trip_int = wd;
                    end
                end
                MCC_OFS_TRIP_EXT: begin
                    if (!state_reg.lock) begin
                        state_next.trip_ext = wd;
                    end
                end
                default: ;
            endcase
        end

        // Reset pulse timing; a primary write in the last cycle
        // keeps what the host wrote instead of the automatic clear,
        // so a request written then is kept; one written earlier in the pulse is cleared
        if (state_reg.rst_cnt != CNT_ZERO) begin
            state_next.rst_cnt = state_reg.rst_cnt - CNT_ONE;
            if (state_reg.rst_cnt == CNT_ONE && !wr_primary) begin
                state_next.primary[MCC_P_RST_REQ] = 1'b0;
            end
        end else if (state_reg.primary[MCC_P_RST_REQ] && state_reg.mask2[MCC_M_RST_EN]) begin
            state_next.rst_cnt = PULSE_LEN;
        end

        // Reads any time
        // Pointer is not readable; foreign offsets come from the value logic
        if (i_bus.data_rd) begin
            state_next.rvalid = 1'b1;
            case (state_reg.pointer)
                MCC_OFS_PRIMARY:   state_next.rdata = state_reg.primary;
                MCC_OFS_SECONDARY: state_next.rdata = state_reg.secondary;
                MCC_OFS_MASK2:     state_next.rdata = state_reg.mask2;
                MCC_OFS_TEST:      state_next.rdata = state_reg.test;
                MCC_OFS_CHMODE:    state_next.rdata = state_reg.chmode;
                MCC_OFS_ANALOG:    state_next.rdata = state_reg.analog;
                MCC_OFS_TRIP_INT:  state_next.rdata = state_reg.trip_int;
                MCC_OFS_TRIP_EXT:  state_next.rdata = state_reg.trip_ext;
                default:           state_next.rdata = i_ext_rdata;
            endcase
        end

        state_next.run_d = run_now;
        state_next.meas_start = run_now && !state_reg.run_d;

        // Alert enable, alert held clear, temp mask
        // Registered so that glitches on the event lines never reach the pin;
        // status contents outside are left alone by the clear
        state_next.alert_n = !(state_reg.primary[MCC_P_ALERT_EN]
                              && !state_reg.primary[MCC_P_ALERT_CLR]
                              && (i_int_event
                                  || (i_temp_event && !state_reg.secondary[MCC_S_TEMP_MASK])));

        // Overtemp enable, overtemp cleared
        // Request comes already shaped by the selected mode
        state_next.ot_drive = state_reg.primary[MCC_P_OT_EN]
                              && !state_reg.primary[MCC_P_OT_CLR]
                              && i_overtemp_req;

        // Pin input synchroniser
        // Only the second flop is read; the first may be metastable
        state_next.ot_sync1 = i_overtemp_pin;
        state_next.ot_sync2 = state_reg.ot_sync1;
    end

    // Loop runs only when started, not suspended, not shut down
    // Shutdown stops the loop without touching any register
    assign run_now = state_reg.primary[MCC_P_START]
                     && !state_reg.primary[MCC_P_ALERT_CLR]
                     && !state_reg.test[MCC_T_SHUTDOWN];

    // Power-on values, loop stopped and alert cleared
    // Primary resets with start low and alert clear high
    always_ff @(posedge i_clock or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            state_reg <= MCC_POR;
        end else begin
            state_reg <= state_next;
        end
    end

    // ========================================================
    // Outputs
    // Bus answer and current pointer
    assign o_ext_addr      = state_reg.pointer;
    assign o_rdata         = state_reg.rdata;
    assign o_rvalid        = state_reg.rvalid;

    // Alert pin, low while an enabled event is pending
    assign o_alert_n       = state_reg.alert_n;

    // Overtemp pin is open drain: data held low, enable pulls the pin
    assign o_overtemp_out  = 1'b0;
    assign o_overtemp_oe   = state_reg.ot_drive;
    assign o_overtemp_ext  = !state_reg.ot_sync2;

    // Reset pin is open drain, pulled low for the whole pulse
    assign o_reset_out     = 1'b0;
    assign o_reset_oe      = (state_reg.rst_cnt != CNT_ZERO);

    // Core control
    assign o_monitor_run   = state_reg.run_d;
    // Shutdown leaves registers as they were
    assign o_low_power     = !state_reg.primary[MCC_P_START];
    assign o_shutdown      = state_reg.test[MCC_T_SHUTDOWN];
    assign o_meas_start    = state_reg.meas_start;

    // Mode and channel setup
    // Overtemp mode select
    assign o_overtemp_mode = state_reg.secondary[MCC_S_OT_MODE];
    assign o_chmode        = state_reg.chmode;

endmodule

// >>> mcc_pkg.sv
// Package with register map, field positions, reset values and state types of the monitor control
package mcc_pkg;

    // ========================================================
    // Register offsets (pointer values)
    localparam logic [7:0] MCC_OFS_TRIP_INT  = 8'h13;
    localparam logic [7:0] MCC_OFS_TRIP_EXT  = 8'h14;
    localparam logic [7:0] MCC_OFS_TEST      = 8'h15;
    localparam logic [7:0] MCC_OFS_CHMODE    = 8'h16;
    localparam logic [7:0] MCC_OFS_ANALOG    = 8'h19;
    localparam logic [7:0] MCC_OFS_PRIMARY   = 8'h40;
    localparam logic [7:0] MCC_OFS_MASK2     = 8'h44;
    localparam logic [7:0] MCC_OFS_SECONDARY = 8'h4A;

    // ========================================================
    // Field positions
    localparam int MCC_P_START     = 0;
    localparam int MCC_P_ALERT_EN  = 1;
    localparam int MCC_P_OT_EN     = 2;
    localparam int MCC_P_ALERT_CLR = 3;
    localparam int MCC_P_RST_REQ   = 4;
    localparam int MCC_P_OT_CLR    = 6;
    localparam int MCC_P_REINIT    = 7;
    localparam int MCC_S_TEMP_MASK = 0;
    localparam int MCC_S_LOCK_A    = 1;
    localparam int MCC_S_LOCK_B    = 2;
    localparam int MCC_S_OT_MODE   = 3;
    localparam int MCC_M_RST_EN    = 7;
    localparam int MCC_T_SHUTDOWN  = 0;

    // ========================================================
    // Reset values
    localparam logic [7:0] MCC_RST_PRIMARY   = 8'h08;
    localparam logic [7:0] MCC_RST_SECONDARY = 8'h00;
    localparam logic [7:0] MCC_RST_MASK2     = 8'h00;
    localparam logic [7:0] MCC_RST_TEST      = 8'h00;
    localparam logic [7:0] MCC_RST_CHMODE    = 8'h00;
    localparam logic [7:0] MCC_RST_ANALOG    = 8'hFF;
    localparam logic [7:0] MCC_RST_TRIP_INT  = 8'h46;
    localparam logic [7:0] MCC_RST_TRIP_EXT  = 8'h55;

    // ========================================================
    // Timing
    localparam int MCC_CLK_HZ         = 50000000;
    localparam int MCC_RST_PULSE_MS   = 45;
    localparam int MCC_RST_PULSE_CYC  = MCC_CLK_HZ / 1000 * MCC_RST_PULSE_MS;
    localparam int MCC_CNT_W          = 22;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic       ptr_wr;
        logic       data_wr;
        logic       data_rd;
        logic [7:0] wdata;
    } mcc_bus_req_t;

    typedef struct packed {
        logic [7:0]           primary;
        logic [7:0]           secondary;
        logic [7:0]           mask2;
        logic [7:0]           test;
        logic [7:0]           chmode;
        logic [7:0]           analog;
        logic [7:0]           trip_int;
        logic [7:0]           trip_ext;
        logic [7:0]           pointer;
        logic                 lock;
        logic [MCC_CNT_W-1:0] rst_cnt;
        logic                 run_d;
        logic                 meas_start;
        logic [7:0]           rdata;
        logic                 rvalid;
        logic                 ot_sync1;
        logic                 ot_sync2;
        logic                 alert_n;
        logic                 ot_drive;
    } mcc_state_t;

endpackage

// >>> mcc_host_model.sv
// Behavioural management host that reaches the control registers through the pointer
`timescale 1ns/1ps
module mcc_host_model
    import mcc_pkg::*;
(
    // Clock and answer from the device
    input  wire logic         i_clock,
    input  wire logic [7:0]   i_rdata,
    input  wire logic         i_rvalid,
    // Request pulses towards the device
    output mcc_bus_req_t      o_bus
);
    initial o_bus = '0;

    // ========================================================
    // Register write: pointer cycle, then data cycle
    // pointer before access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock) #1;
        o_bus = {1'b1, 1'b0, 1'b0, a};
        @(posedge i_clock) #1;
        o_bus = {1'b0, 1'b1, 1'b0, d};
        @(posedge i_clock) #1;
        o_bus = {3'b000, ~d}; // Released data no longer shows the last byte
    endtask

    // ========================================================
    // Register read: answer stands one cycle, taken while it stands
    // pointer before access
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock) #1;
        o_bus = {1'b1, 1'b0, 1'b0, a};
        @(posedge i_clock) #1;
        o_bus = {1'b0, 1'b0, 1'b1, ~a};
        @(posedge i_clock) #1;
        o_bus = {3'b000, a};
        d = i_rvalid ? i_rdata : 8'hXX;
    endtask
endmodule

// >>> mcc_monitor_config_control_assertions.sv
// Port-level checker of the monitor control register bank
`timescale 1ns/1ps
module mcc_monitor_config_control_checker
    import mcc_pkg::*;
#(
    parameter int RST_PULSE_CYC = MCC_RST_PULSE_CYC
) (
    // Clock, reset and requests
    input  wire logic         i_clock,
    input  wire logic         i_resetn,
    input  wire mcc_bus_req_t i_bus,
    input  wire logic         i_int_event,
    input  wire logic         i_temp_event,
    input  wire logic         i_overtemp_req,
    // Observed outputs
    input  wire logic [7:0]   o_ext_addr,
    input  wire logic         o_rvalid,
    input  wire logic         o_overtemp_oe,
    input  wire logic         o_reset_out,
    input  wire logic         o_reset_oe,
    input  wire logic         o_alert_n,
    input  wire logic         o_monitor_run,
    input  wire logic         o_low_power,
    input  wire logic         o_shutdown,
    input  wire logic         o_meas_start
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    // ========================================================
    // Length of the current reset pulse in cycles
    int hi_cnt_reg;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            hi_cnt_reg <= 0;
        end else begin
            hi_cnt_reg <= o_reset_oe ? hi_cnt_reg + 1 : 0;
        end
    end

    // ========================================================
    // Properties
    rd_answer_a: assert property (i_bus.data_rd |=> o_rvalid)
        else $error("read got no answer");
    rd_cause_a: assert property (o_rvalid |-> $past(i_bus.data_rd))
        else $error("answer without a read");
    ptr_load_a: assert property (i_bus.ptr_wr |=> o_ext_addr == $past(i_bus.wdata))
        else $error("pointer not loaded");
    lp_stop_a: assert property (o_low_power |=> !o_monitor_run)
        else $error("loop runs in low power");
    sd_stop_a: assert property (o_shutdown [*2] |-> !o_monitor_run)
        else $error("loop runs in shutdown");
    meas_go_a: assert property ($rose(o_monitor_run) |-> ##[0:1] o_meas_start)
        else $error("no measurement start");
    meas_pulse_a: assert property (o_meas_start |=> !o_meas_start)
        else $error("start pulse too long");
    rst_len_a: assert property ($fell(o_reset_oe) |-> hi_cnt_reg == RST_PULSE_CYC)
        else $error("reset pulse length wrong");
    rst_low_a: assert property (o_reset_oe |-> !o_reset_out)
        else $error("reset pin not driven low");
    ot_cause_a: assert property (o_overtemp_oe |-> $past(i_overtemp_req))
        else $error("overtemp driven without cause");
    alert_cause_a: assert property (!o_alert_n |-> $past(i_int_event || i_temp_event))
        else $error("alert without event");

    // Main scenarios reached
    cover property ($fell(o_reset_oe));
    cover property (o_meas_start);
    cover property (!o_alert_n ##1 o_alert_n);
endmodule

bind mcc_monitor_config_control mcc_monitor_config_control_checker #(
    .RST_PULSE_CYC(RST_PULSE_CYC)
) chk (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_bus(i_bus),
    .i_int_event(i_int_event), .i_temp_event(i_temp_event),
    .i_overtemp_req(i_overtemp_req), .o_ext_addr(o_ext_addr), .o_rvalid(o_rvalid),
    .o_overtemp_oe(o_overtemp_oe), .o_reset_out(o_reset_out), .o_reset_oe(o_reset_oe),
    .o_alert_n(o_alert_n), .o_monitor_run(o_monitor_run), .o_low_power(o_low_power),
    .o_shutdown(o_shutdown), .o_meas_start(o_meas_start)
);

// >>> tb_monitor_config_control.sv
// Self-checking bench of the monitor control register bank
`timescale 1ns/1ps
module tb_monitor_config_control;
    import mcc_pkg::*;
    localparam int PCYC = 20;
    logic         i_clock = 1'b0;
    logic         i_resetn = 1'b0;
    logic         i_int_event = 1'b0;
    logic         i_temp_event = 1'b0;
    logic         i_overtemp_req = 1'b0;
    logic [7:0]   i_ext_rdata = 8'hA5;
    logic         ot_pin = 1'b1;
    mcc_bus_req_t bus;
    logic [7:0]   rdata, ext_addr, chmode;
    logic         rvalid, ot_out, ot_oe, ot_ext, rst_out, rst_oe;
    logic         alert_n, run, lp, sd, ms, otm;
    int           err_count = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    int           starts = 0;
    logic [7:0]   ofs[8] = '{MCC_OFS_PRIMARY, MCC_OFS_SECONDARY, MCC_OFS_MASK2, MCC_OFS_TEST,
                             MCC_OFS_CHMODE, MCC_OFS_ANALOG, MCC_OFS_TRIP_INT, MCC_OFS_TRIP_EXT};
    logic [7:0]   rst[8] = '{MCC_RST_PRIMARY, MCC_RST_SECONDARY, MCC_RST_MASK2, MCC_RST_TEST,
                             MCC_RST_CHMODE, MCC_RST_ANALOG, MCC_RST_TRIP_INT, MCC_RST_TRIP_EXT};

    mcc_monitor_config_control #(.RST_PULSE_CYC(PCYC)) uut (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_bus(bus), .i_ext_rdata(i_ext_rdata),
        .o_ext_addr(ext_addr), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_int_event(i_int_event), .i_temp_event(i_temp_event),
        .i_overtemp_req(i_overtemp_req), .i_overtemp_pin(ot_pin), .o_overtemp_out(ot_out),
        .o_overtemp_oe(ot_oe), .o_overtemp_ext(ot_ext), .o_reset_out(rst_out),
        .o_reset_oe(rst_oe), .o_alert_n(alert_n), .o_monitor_run(run), .o_low_power(lp),
        .o_shutdown(sd), .o_meas_start(ms), .o_overtemp_mode(otm), .o_chmode(chmode)
    );
    mcc_host_model host (.i_clock(i_clock), .i_rdata(rdata), .i_rvalid(rvalid), .o_bus(bus));

    // ========================================================
    // Clock, hang guard and shared tasks
    initial begin
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc++;
        if (ms === 1'b1) starts++;
        if (cyc == 5000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk($sformatf("reg %h", a), d, e);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ========================================================
    // Scenarios
    initial begin
        int n;
        n = 0;
        tick(3);
        i_resetn = 1'b1;
        tick(3);
        host.wr(8'h2B, 8'h50);
        chk("pointer", ext_addr, 8'h2B);
        foreach (ofs[i]) rchk(ofs[i], rst[i]);
        chk("alert_n", 8'(alert_n), 8'h01);
        chk("run", 8'(run), 8'h00);
        rchk(8'h20, 8'hA5);
        // Writes while the loop is stopped
        host.wr(MCC_OFS_CHMODE, 8'h5A);
        host.wr(MCC_OFS_ANALOG, 8'h3C);
        host.wr(MCC_OFS_TRIP_INT, 8'h11);
        host.wr(MCC_OFS_SECONDARY, 8'h08);
        tick(2);
        chk("chmode", chmode, 8'h5A);
        chk("ot mode", 8'(otm), 8'h01);
        rchk(MCC_OFS_TRIP_INT, 8'h11);
        // Start with enables set and clears low
        host.wr(MCC_OFS_PRIMARY, 8'h07);
        i_int_event = 1'b1;
        tick(3);
        chk("run", 8'(run), 8'h01);
        chk("low power", 8'(lp), 8'h00);
        chk("alert_n", 8'(alert_n), 8'h00);
        host.wr(MCC_OFS_PRIMARY, 8'h0F);
        tick(3);
        chk("alert_n", 8'(alert_n), 8'h01);
        chk("run", 8'(run), 8'h00);
        rchk(MCC_OFS_PRIMARY, 8'h0F);
        host.wr(MCC_OFS_PRIMARY, 8'h05);
        tick(3);
        chk("alert_n", 8'(alert_n), 8'h01);
        // Temperature events masked from the alert
        i_int_event = 1'b0;
        i_temp_event = 1'b1;
        host.wr(MCC_OFS_SECONDARY, 8'h01);
        host.wr(MCC_OFS_PRIMARY, 8'h07);
        tick(3);
        chk("alert_n", 8'(alert_n), 8'h01);
        host.wr(MCC_OFS_SECONDARY, 8'h00);
        tick(3);
        chk("alert_n", 8'(alert_n), 8'h00);
        i_temp_event = 1'b0;
        // Overtemp pin enable and clear
        i_overtemp_req = 1'b1;
        tick(3);
        chk("ot drive", 8'(ot_oe), 8'h01);
        chk("ot pin level", 8'(ot_out), 8'h00);
        ot_pin = 1'b0;
        tick(3);
        chk("ot pin seen", 8'(ot_ext), 8'h01);
        ot_pin = 1'b1;
        host.wr(MCC_OFS_PRIMARY, 8'h47);
        tick(3);
        chk("ot drive", 8'(ot_oe), 8'h00);
        rchk(MCC_OFS_PRIMARY, 8'h47);
        host.wr(MCC_OFS_PRIMARY, 8'h03);
        tick(3);
        chk("ot drive", 8'(ot_oe), 8'h00);
        i_overtemp_req = 1'b0;
        // Full shutdown and return
        host.wr(MCC_OFS_PRIMARY, 8'h01);
        host.wr(MCC_OFS_TEST, 8'h01);
        tick(3);
        chk("shutdown", 8'(sd), 8'h01);
        chk("run", 8'(run), 8'h00);
        rchk(MCC_OFS_PRIMARY, 8'h01);
        host.wr(MCC_OFS_TEST, 8'h00);
        tick(3);
        chk("run", 8'(run), 8'h01);
        // Reset pulse refused, then granted
        host.wr(MCC_OFS_PRIMARY, 8'h11);
        tick(2);
        chk("reset drive", 8'(rst_oe), 8'h00);
        rchk(MCC_OFS_PRIMARY, 8'h01);
        host.wr(MCC_OFS_MASK2, 8'h80);
        host.wr(MCC_OFS_PRIMARY, 8'h11);
        repeat (2 * PCYC) begin
            if (rst_oe === 1'b1 && rst_out === 1'b0) n++;
            tick(1);
        end
        chk("pulse length", 8'(n), 8'(PCYC));
        rchk(MCC_OFS_PRIMARY, 8'h01);
        // Trip lock, then re-initialisation
        host.wr(MCC_OFS_SECONDARY, 8'h06);
        host.wr(MCC_OFS_TRIP_INT, 8'h22);
        rchk(MCC_OFS_TRIP_INT, 8'h11);
        host.wr(MCC_OFS_PRIMARY, 8'h80);
        tick(2);
        rchk(MCC_OFS_PRIMARY, MCC_RST_PRIMARY);
        rchk(MCC_OFS_ANALOG, 8'h3C);
        rchk(MCC_OFS_CHMODE, MCC_RST_CHMODE);
        rchk(MCC_OFS_MASK2, MCC_RST_MASK2);
        rchk(MCC_OFS_TRIP_INT, 8'h11);
        chk("start pulses", 8'(starts), 8'h03);
        // Power-on reset again frees the trip lock
        i_resetn = 1'b0;
        tick(3);
        i_resetn = 1'b1;
        tick(3);
        rchk(MCC_OFS_TRIP_INT, MCC_RST_TRIP_INT);
        host.wr(MCC_OFS_TRIP_INT, 8'h22);
        rchk(MCC_OFS_TRIP_INT, 8'h22);
        give_verdict();
    end
endmodule
